/* shared/dcad_pkg.sv */
// dcad_pkg: constants and types for the command/address decoder
// assumes: one 100 MHz clock, inputs already sampled on the rising edge
package dcad_pkg;
    localparam int ADDR_W = 18;
    localparam int ROW_W_DEF = 15;
    localparam int COL_W_DEF = 10;
    localparam int BANK_W = 2;
    localparam int GROUP_W = 1;
    localparam int AUTOCLOSE_BIT = 10;
    localparam int SHORTEN_BIT = 12;
    localparam int ADDR14_BIT = 14;
    localparam int ADDR15_BIT = 15;
    localparam int ADDR16_BIT = 16;
    localparam int ADDR17_BIT = 17;
    localparam int MR_SEL_W = GROUP_W + BANK_W;

    // strobe code {row, col, write}, all active low
    localparam logic [2:0] CODE_MRW = 3'h0;
    localparam logic [2:0] CODE_REF = 3'h1;
    localparam logic [2:0] CODE_PRE = 3'h2;
    localparam logic [2:0] CODE_WR = 3'h4;
    localparam logic [2:0] CODE_RD = 3'h5;

    typedef enum logic [2:0] {
        DCAD_CMD_NONE = 3'h0,
        DCAD_CMD_ACT = 3'h1,
        DCAD_CMD_RD = 3'h3,
        DCAD_CMD_WR = 3'h2,
        DCAD_CMD_PRE = 3'h6,
        DCAD_CMD_REF = 3'h7,
        DCAD_CMD_MRW = 3'h5,
        DCAD_CMD_OTHER = 3'h4
    } dcad_cmd_t;
endpackage : dcad_pkg

/* shared/dcad_if.sv */
// dcad_if: sampled pin bundle between the capture stage and the decoder
// assumes: both ends run on the same clock
`timescale 1ns/1ps
interface dcad_if;
    logic sel_low;
    logic row_open_strobe_low;
    logic row_strobe_or_addr16;
    logic col_strobe_or_addr15;
    logic write_strobe_or_addr14;
    logic [dcad_pkg::ADDR_W-1:0] addr;
    logic [dcad_pkg::BANK_W-1:0] bank;
    logic [dcad_pkg::GROUP_W-1:0] group_select;
    logic low_byte_mask_low;
    modport src (output sel_low, row_open_strobe_low, row_strobe_or_addr16,
        col_strobe_or_addr15, write_strobe_or_addr14, addr, bank,
        group_select, low_byte_mask_low);
    modport dst (input sel_low, row_open_strobe_low, row_strobe_or_addr16,
        col_strobe_or_addr15, write_strobe_or_addr14, addr, bank,
        group_select, low_byte_mask_low);
endinterface : dcad_if

/* hw/dcad_capture.sv */
// dcad_capture: registers every command/address pin on the rising edge
// assumes: the pins are synchronous to clk, driven by the controller
`timescale 1ns/1ps
module dcad_capture (
    input wire logic clk, // rising edge is the sampling crossing
    input wire logic resetn, // synchronous, active low
    input wire logic cs_low, // chip select, active low
    input wire logic row_open_strobe_low, // activate strobe
    input wire logic row_strobe_or_addr16, // shared pin
    input wire logic col_strobe_or_addr15, // shared pin
    input wire logic write_strobe_or_addr14, // shared pin
    input wire logic [dcad_pkg::ADDR_W-1:0] addr, // address inputs
    input wire logic [dcad_pkg::BANK_W-1:0] bank, // bank inputs
    input wire logic [dcad_pkg::GROUP_W-1:0] group_select, // group input
    input wire logic low_byte_mask_low, // shared mask ball
    dcad_if.src smp // sampled bundle
);
    logic next_sel_low;

    // ------------------------------------------------------------
    // sampling stage
    // ------------------------------------------------------------
    always_comb begin
        next_sel_low = cs_low;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            smp.sel_low <= 1'b1;
            smp.row_open_strobe_low <= 1'b1;
            smp.row_strobe_or_addr16 <= 1'b1;
            smp.col_strobe_or_addr15 <= 1'b1;
            smp.write_strobe_or_addr14 <= 1'b1;
            smp.addr <= '0;
            smp.bank <= '0;
            smp.group_select <= '0;
            smp.low_byte_mask_low <= 1'b1;
        end else begin
            smp.sel_low <= next_sel_low;
            smp.row_open_strobe_low <= row_open_strobe_low;
            smp.row_strobe_or_addr16 <= row_strobe_or_addr16;
            smp.col_strobe_or_addr15 <= col_strobe_or_addr15;
            smp.write_strobe_or_addr14 <= write_strobe_or_addr14;
            smp.addr <= addr;
            smp.bank <= bank;
            smp.group_select <= group_select;
            smp.low_byte_mask_low <= low_byte_mask_low;
        end
    end
endmodule : dcad_capture

/* hw/dcad_decode.sv */
// dcad_decode: command/address decoder of a x16 memory device
// assumes: controller-driven pins synchronous to clk; stack ids unused
`timescale 1ns/1ps
module dcad_decode #(
    parameter int ROW_W = dcad_pkg::ROW_W_DEF, // row bits used by density
    parameter int COL_W = dcad_pkg::COL_W_DEF // column bits
) (
    input wire logic clk, // 100 MHz
    input wire logic resetn, // synchronous, active low
    input wire logic cs_low, // chip select, active low
    input wire logic row_open_strobe_low, // activate strobe, active low
    input wire logic row_strobe_or_addr16, // row strobe or row bit 16
    input wire logic col_strobe_or_addr15, // column strobe or row bit 15
    input wire logic write_strobe_or_addr14, // write strobe or row bit 14
    input wire logic [dcad_pkg::ADDR_W-1:0] addr, // address inputs
    input wire logic [dcad_pkg::BANK_W-1:0] bank, // bank inputs
    input wire logic [1:0] group_select, // group inputs, bit 1 unused
    input wire logic stack_id0, // ignored
    input wire logic stack_id1, // ignored
    input wire logic stack_id2, // ignored
    input wire logic low_byte_mask_low, // shared mask ball
    input wire logic mask_enable, // masking enabled by mode setting
    output logic cmd_valid, // one-cycle pulse, command decoded
    output dcad_pkg::dcad_cmd_t cmd_type, // decoded command
    output logic [ROW_W-1:0] row_addr, // activate row
    output logic [COL_W-1:0] col_addr, // read/write column
    output logic [dcad_pkg::BANK_W-1:0] bank_addr, // bank in group
    output logic [dcad_pkg::GROUP_W-1:0] group_addr, // group
    output logic autoclose, // read/write autoclose request
    output logic close_all, // precharge of all banks
    output logic burst_short, // read/write shortened burst
    output logic [dcad_pkg::ADDR_W-1:0] mr_opcode, // mode reg opcode
    output logic [dcad_pkg::MR_SEL_W-1:0] mr_select, // mode reg number
    output logic low_mask_active // lower byte mask asserted
);
    // parameter range checks, refused at elaboration
    if (ROW_W < 14 || ROW_W > dcad_pkg::ADDR_W) begin : g_bad_row
        $error("ROW_W out of range");
    end
    if (COL_W < 1 || COL_W > dcad_pkg::AUTOCLOSE_BIT) begin : g_bad_col
        $error("COL_W out of range");
    end

    dcad_if smp ();

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    dcad_capture u_capture (
        .clk(clk),
        .resetn(resetn),
        .cs_low(cs_low),
        .row_open_strobe_low(row_open_strobe_low),
        .row_strobe_or_addr16(row_strobe_or_addr16),
        .col_strobe_or_addr15(col_strobe_or_addr15),
        .write_strobe_or_addr14(write_strobe_or_addr14),
        .addr(addr),
        .bank(bank),
        .group_select(group_select[dcad_pkg::GROUP_W-1:0]),
        .low_byte_mask_low(low_byte_mask_low),
        .smp(smp)
    );

    // stack ids and upper group bit have no use in this organisation
    logic unused_ok;
    assign unused_ok = stack_id0 ^ stack_id1 ^ stack_id2 ^ group_select[1];

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    dcad_pkg::dcad_cmd_t dec_cmd;
    logic [dcad_pkg::ADDR_W-1:0] full_row;
    logic [2:0] code;

    always_comb begin
        code = {smp.row_strobe_or_addr16, smp.col_strobe_or_addr15,
            smp.write_strobe_or_addr14};
        full_row = smp.addr;
        full_row[dcad_pkg::ADDR16_BIT] = smp.row_strobe_or_addr16;
        full_row[dcad_pkg::ADDR15_BIT] = smp.col_strobe_or_addr15;
        full_row[dcad_pkg::ADDR14_BIT] = smp.write_strobe_or_addr14;
        if (smp.sel_low) begin
            dec_cmd = dcad_pkg::DCAD_CMD_NONE;
        end else if (!smp.row_open_strobe_low) begin
            dec_cmd = dcad_pkg::DCAD_CMD_ACT;
        end else begin
            case (code)
                dcad_pkg::CODE_MRW: dec_cmd = dcad_pkg::DCAD_CMD_MRW;
                dcad_pkg::CODE_REF: dec_cmd = dcad_pkg::DCAD_CMD_REF;
                dcad_pkg::CODE_PRE: dec_cmd = dcad_pkg::DCAD_CMD_PRE;
                dcad_pkg::CODE_WR: dec_cmd = dcad_pkg::DCAD_CMD_WR;
                dcad_pkg::CODE_RD: dec_cmd = dcad_pkg::DCAD_CMD_RD;
                default: dec_cmd = dcad_pkg::DCAD_CMD_OTHER;
            endcase
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic next_cmd_valid;
    dcad_pkg::dcad_cmd_t next_cmd_type;
    logic [ROW_W-1:0] next_row_addr;
    logic [COL_W-1:0] next_col_addr;
    logic [dcad_pkg::BANK_W-1:0] next_bank_addr;
    logic [dcad_pkg::GROUP_W-1:0] next_group_addr;
    logic next_autoclose;
    logic next_close_all;
    logic next_burst_short;
    logic [dcad_pkg::ADDR_W-1:0] next_mr_opcode;
    logic [dcad_pkg::MR_SEL_W-1:0] next_mr_select;
    logic next_low_mask_active;
    logic is_rw;

    always_comb begin
        is_rw = (dec_cmd == dcad_pkg::DCAD_CMD_RD) ||
            (dec_cmd == dcad_pkg::DCAD_CMD_WR);
        next_cmd_valid = (dec_cmd != dcad_pkg::DCAD_CMD_NONE);
        next_cmd_type = dec_cmd;
        next_row_addr = row_addr;
        next_col_addr = col_addr;
        next_bank_addr = bank_addr;
        next_group_addr = group_addr;
        next_autoclose = 1'b0;
        next_close_all = 1'b0;
        next_burst_short = 1'b0;
        next_mr_opcode = mr_opcode;
        next_mr_select = mr_select;
        // bits above the density width are dropped, never addressed
        if (dec_cmd == dcad_pkg::DCAD_CMD_ACT) begin
            next_row_addr = full_row[ROW_W-1:0];
        end
        if (is_rw) begin
            next_col_addr = smp.addr[COL_W-1:0];
            next_autoclose = smp.addr[dcad_pkg::AUTOCLOSE_BIT];
            next_burst_short = !smp.addr[dcad_pkg::SHORTEN_BIT];
        end
        if (dec_cmd == dcad_pkg::DCAD_CMD_PRE) begin
            next_close_all = smp.addr[dcad_pkg::AUTOCLOSE_BIT];
        end
        if (is_rw || dec_cmd == dcad_pkg::DCAD_CMD_ACT ||
            dec_cmd == dcad_pkg::DCAD_CMD_PRE) begin
            next_bank_addr = smp.bank;
        end
        if (is_rw || dec_cmd == dcad_pkg::DCAD_CMD_ACT ||
            dec_cmd == dcad_pkg::DCAD_CMD_PRE ||
            dec_cmd == dcad_pkg::DCAD_CMD_REF) begin
            next_group_addr = smp.group_select;
        end
        if (dec_cmd == dcad_pkg::DCAD_CMD_MRW) begin
            next_mr_opcode = smp.addr;
            next_mr_select = {smp.group_select, smp.bank};
        end
        next_low_mask_active = mask_enable && !smp.low_byte_mask_low;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_valid <= 1'b0;
            cmd_type <= dcad_pkg::DCAD_CMD_NONE;
            row_addr <= '0;
            col_addr <= '0;
            bank_addr <= '0;
            group_addr <= '0;
            autoclose <= 1'b0;
            close_all <= 1'b0;
            burst_short <= 1'b0;
            mr_opcode <= '0;
            mr_select <= '0;
            low_mask_active <= 1'b0;
        end else begin
            cmd_valid <= next_cmd_valid;
            cmd_type <= next_cmd_type;
            row_addr <= next_row_addr;
            col_addr <= next_col_addr;
            bank_addr <= next_bank_addr;
            group_addr <= next_group_addr;
            autoclose <= next_autoclose;
            close_all <= next_close_all;
            burst_short <= next_burst_short;
            mr_opcode <= next_mr_opcode;
            mr_select <= next_mr_select;
            low_mask_active <= next_low_mask_active;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_act_in;
        !cs_low && !row_open_strobe_low;
    endsequence

    sequence s_rd_in;
        !cs_low && row_open_strobe_low && row_strobe_or_addr16 &&
            !col_strobe_or_addr15 && write_strobe_or_addr14;
    endsequence

    sequence s_wr_in;
        !cs_low && row_open_strobe_low && row_strobe_or_addr16 &&
            !col_strobe_or_addr15 && !write_strobe_or_addr14;
    endsequence

    sequence s_pre_in;
        !cs_low && row_open_strobe_low && !row_strobe_or_addr16 &&
            col_strobe_or_addr15 && !write_strobe_or_addr14;
    endsequence

    sequence s_ref_in;
        !cs_low && row_open_strobe_low && !row_strobe_or_addr16 &&
            !col_strobe_or_addr15 && write_strobe_or_addr14;
    endsequence

    sequence s_mrw_in;
        !cs_low && row_open_strobe_low && !row_strobe_or_addr16 &&
            !col_strobe_or_addr15 && !write_strobe_or_addr14;
    endsequence

    property p_masked;
        @(posedge clk) disable iff (!resetn)
            cs_low |=> ##1 !cmd_valid;
    endproperty
    a_masked: assert property (p_masked)
        else $error("command decoded while deselected");

    property p_act;
        @(posedge clk) disable iff (!resetn)
            s_act_in |=> ##1 (cmd_valid && cmd_type == dcad_pkg::DCAD_CMD_ACT
                && row_addr == $past(full_row[ROW_W-1:0]));
    endproperty
    a_act: assert property (p_act)
        else $error("activate not decoded with its row");

    property p_rd;
        @(posedge clk) disable iff (!resetn)
            s_rd_in |=> ##1 (cmd_type == dcad_pkg::DCAD_CMD_RD &&
                col_addr == $past(addr[COL_W-1:0], 2));
    endproperty
    a_rd: assert property (p_rd)
        else $error("read column wrong");

    property p_autoclose;
        @(posedge clk) disable iff (!resetn)
            s_rd_in |=> ##1 (autoclose == $past(addr[dcad_pkg::AUTOCLOSE_BIT],
                2));
    endproperty
    a_autoclose: assert property (p_autoclose)
        else $error("autoclose flag wrong");

    property p_short;
        @(posedge clk) disable iff (!resetn)
            s_rd_in |=> ##1 (burst_short ==
                !$past(addr[dcad_pkg::SHORTEN_BIT], 2));
    endproperty
    a_short: assert property (p_short)
        else $error("burst shorten flag wrong");

    property p_close_all;
        @(posedge clk) disable iff (!resetn)
            close_all |-> cmd_type == dcad_pkg::DCAD_CMD_PRE;
    endproperty
    a_close_all: assert property (p_close_all)
        else $error("close all outside precharge");

    property p_mrw;
        @(posedge clk) disable iff (!resetn)
            (cmd_valid && cmd_type == dcad_pkg::DCAD_CMD_MRW) |->
                (mr_opcode == $past(addr, 2) &&
                mr_select == {$past(group_select[0], 2), $past(bank, 2)});
    endproperty
    a_mrw: assert property (p_mrw)
        else $error("mode register write fields wrong");

    property p_mask;
        @(posedge clk) disable iff (!resetn)
            !mask_enable |=> !low_mask_active;
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask active while disabled");

    property p_wr;
        @(posedge clk) disable iff (!resetn)
            s_wr_in |=> ##1 (cmd_valid && cmd_type == dcad_pkg::DCAD_CMD_WR
                && col_addr == $past(addr[COL_W-1:0], 2));
    endproperty
    a_wr: assert property (p_wr)
        else $error("write column wrong");

    property p_pre;
        @(posedge clk) disable iff (!resetn)
            s_pre_in |=> ##1 (cmd_type == dcad_pkg::DCAD_CMD_PRE &&
                close_all == $past(addr[dcad_pkg::AUTOCLOSE_BIT], 2) &&
                bank_addr == $past(bank, 2));
    endproperty
    a_pre: assert property (p_pre)
        else $error("precharge fields wrong");

    property p_ref_group;
        @(posedge clk) disable iff (!resetn)
            s_ref_in |=> ##1 (cmd_type == dcad_pkg::DCAD_CMD_REF &&
                group_addr == $past(group_select[0], 2));
    endproperty
    a_ref_group: assert property (p_ref_group)
        else $error("refresh group wrong");

    property p_mrw_code;
        @(posedge clk) disable iff (!resetn)
            s_mrw_in |=> ##1 (cmd_valid &&
                cmd_type == dcad_pkg::DCAD_CMD_MRW);
    endproperty
    a_mrw_code: assert property (p_mrw_code)
        else $error("mode register write not decoded");

    property p_flags_idle;
        @(posedge clk) disable iff (!resetn)
            !cmd_valid |-> !(autoclose || close_all || burst_short);
    endproperty
    a_flags_idle: assert property (p_flags_idle)
        else $error("qualifier flag without command");
endmodule : dcad_decode

/* tb/dcad_ctrl_model.sv */
// dcad_ctrl_model: controller side driving the command/address pins
// assumes: same clk as the decoder; driven by tasks called from tb
`timescale 1ns/1ps
module dcad_ctrl_model (
    input wire logic clk, // shared clock
    output logic cs_low, // chip select, active low
    output logic row_open_strobe_low, // activate strobe, active low
    output logic [2:0] strobes, // shared pins row, col, write
    output logic [17:0] addr, // address inputs
    output logic [1:0] bank, // bank inputs
    output logic [1:0] group_select, // group inputs
    output logic [2:0] stack_id, // stack ids, unused by x16
    output logic low_byte_mask_low // lower mask ball
);
    int seed = 18;

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    initial begin
        cs_low = 1'b1;
        row_open_strobe_low = 1'b1;
        strobes = 3'h7;
        addr = 18'h0;
        bank = 2'h0;
        group_select = 2'h0;
        stack_id = 3'h0;
        low_byte_mask_low = 1'b1;
    end

    // mask ball moves freely; decoder decides whether it counts
    always @(posedge clk) low_byte_mask_low <= 1'($random(seed));

    // one command cycle; stack ids take a random value each call
    task automatic issue(input logic cs, input logic act,
        input logic [2:0] sh, input logic [17:0] a, input logic [1:0] b,
        input logic [1:0] g);
        @(posedge clk);
        cs_low <= cs;
        row_open_strobe_low <= act;
        strobes <= sh;
        addr <= a;
        bank <= b;
        group_select <= g;
        stack_id <= 3'($random(seed));
    endtask : issue

    // deselect; act, strobe, address, bank and group lines show the inverse of their last value
    task automatic idle();
        @(posedge clk);
        cs_low <= 1'b1;
        row_open_strobe_low <= ~row_open_strobe_low;
        strobes <= ~strobes;
        addr <= ~addr;
        bank <= ~bank;
        group_select <= ~group_select;
    endtask : idle
endmodule : dcad_ctrl_model

/* tb/tb.sv */
// tb: self-checking bench for the command/address decoder
// assumes: dcad_pkg compiled first; controller model drives the pins
`timescale 1ns/1ps
module tb;
    localparam int ROW_W = 17;
    localparam int COL_W = 10;
    typedef struct {
        dcad_pkg::dcad_cmd_t t;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [1:0] bank;
        logic grp, ac, ca, bs, is_act, is_rw, is_mrw, kb, kg;
        logic [17:0] op;
        logic [2:0] sel;
        int cyc;
    } dcad_note_t;
    logic clk, resetn, mask_enable, mask_chk, cs_low, act_low, mask_low;
    logic mask_exp;
    logic cmd_valid, autoclose, close_all, burst_short, low_mask_active;
    logic [2:0] strobes, stack_id, mr_select;
    logic [17:0] addr, mr_opcode;
    logic [1:0] bank, group_select, bank_addr;
    logic [1:0] hist = 2'h0;
    logic [dcad_pkg::GROUP_W-1:0] group_addr;
    logic [ROW_W-1:0] row_addr;
    logic [COL_W-1:0] col_addr;
    dcad_pkg::dcad_cmd_t cmd_type;
    logic en_prev = 1'b0;
    int seed = 18;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int en_cnt = 0;
    dcad_note_t n;
    dcad_note_t notes[$];

    dcad_ctrl_model i_dcad_ctrl_model (.clk(clk), .cs_low(cs_low),
        .row_open_strobe_low(act_low), .strobes(strobes), .addr(addr),
        .bank(bank), .group_select(group_select), .stack_id(stack_id),
        .low_byte_mask_low(mask_low));
    dcad_decode #(.ROW_W(ROW_W), .COL_W(COL_W)) i_dcad_decode (
        .clk(clk), .resetn(resetn), .cs_low(cs_low),
        .row_open_strobe_low(act_low), .row_strobe_or_addr16(strobes[2]),
        .col_strobe_or_addr15(strobes[1]),
        .write_strobe_or_addr14(strobes[0]), .addr(addr), .bank(bank),
        .group_select(group_select), .stack_id0(stack_id[0]),
        .stack_id1(stack_id[1]), .stack_id2(stack_id[2]),
        .low_byte_mask_low(mask_low), .mask_enable(mask_enable),
        .cmd_valid(cmd_valid), .cmd_type(cmd_type), .row_addr(row_addr),
        .col_addr(col_addr), .bank_addr(bank_addr), .group_addr(group_addr),
        .autoclose(autoclose), .close_all(close_all),
        .burst_short(burst_short), .mr_opcode(mr_opcode),
        .mr_select(mr_select), .low_mask_active(low_mask_active));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // stimulus: drive one command and note what must come out
    // ------------------------------------------------------------
    task automatic send(input logic cs, input logic act,
        input logic [2:0] sh, input logic a10, input logic a12);
        dcad_note_t e;
        logic [17:0] a;
        logic [1:0] b, g;
        logic pre;
        a = 18'($random(seed));
        a[10] = a10;
        a[12] = a12;
        b = 2'($random(seed));
        g = 2'($random(seed));
        case (sh)
            dcad_pkg::CODE_MRW: e.t = dcad_pkg::DCAD_CMD_MRW;
            dcad_pkg::CODE_REF: e.t = dcad_pkg::DCAD_CMD_REF;
            dcad_pkg::CODE_PRE: e.t = dcad_pkg::DCAD_CMD_PRE;
            dcad_pkg::CODE_WR: e.t = dcad_pkg::DCAD_CMD_WR;
            dcad_pkg::CODE_RD: e.t = dcad_pkg::DCAD_CMD_RD;
            default: e.t = dcad_pkg::DCAD_CMD_OTHER;
        endcase
        if (!act)
            e.t = dcad_pkg::DCAD_CMD_ACT;
        pre = act && sh == dcad_pkg::CODE_PRE;
        e.is_act = !act;
        e.is_rw = act && (sh == dcad_pkg::CODE_RD || sh == dcad_pkg::CODE_WR);
        e.is_mrw = act && sh == dcad_pkg::CODE_MRW;
        e.ac = e.is_rw & a10;
        e.ca = pre & a10;
        e.bs = e.is_rw & !a12;
        e.kb = e.is_act | e.is_rw | (pre & !a10);
        e.kg = e.kb | (act && sh == dcad_pkg::CODE_REF);
        e.row = ROW_W'({a[17], sh, a[13:0]});
        e.col = a[COL_W-1:0];
        e.bank = b;
        e.grp = g[0];
        e.op = a;
        e.sel = {g[0], b};
        i_dcad_ctrl_model.issue(cs, act, sh, a, b, g);
        e.cyc = cyc + 3;
        if (!cs)
            notes.push_back(e);
    endtask : send

    initial begin
        resetn = 1'b0;
        mask_enable = 1'b0;
        mask_chk = 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check("reset cmd_valid", cmd_valid, 0);
        check("reset cmd_type", cmd_type, dcad_pkg::DCAD_CMD_NONE);
        i_dcad_ctrl_model.idle();
        for (int i = 0; i < 32; i++)
            send(1'b0, 1'b1, 3'(i), i[3], i[4]);
        $display("test command codes done");
        for (int i = 0; i < 12; i++)
            send(1'b0, 1'b0, 3'($random(seed)), i[0], i[1]);
        $display("test activate rows done");
        for (int i = 0; i < 16; i++)
            send(i[0], 1'($random(seed)), 3'($random(seed)), i[1], i[2]);
        $display("test deselect done");
        mask_chk <= 1'b1;
        mask_enable <= 1'b1;
        repeat (20) i_dcad_ctrl_model.idle();
        mask_enable <= 1'b0;
        repeat (20) i_dcad_ctrl_model.idle();
        $display("test mask done");
        repeat (4) i_dcad_ctrl_model.idle();
        check("pending notes", notes.size(), 0);
        give_verdict();
    end

    // ------------------------------------------------------------
    // monitor: compare each decoded command with the oldest note
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            num_errors++;
            give_verdict();
        end
    end

    always @(posedge clk) begin
        #1;
        en_cnt = (mask_enable === en_prev) ? en_cnt + 1 : 0;
        en_prev = mask_enable;
        mask_exp = mask_enable & ~hist[1];
        if (mask_chk && en_cnt >= 3)
            check("low_mask_active", low_mask_active, mask_exp);
        hist = {hist[0], mask_low};
        if (cmd_valid === 1'b1 && notes.size() == 0)
            check("stray command", 1, 0);
        else if (cmd_valid === 1'b1) begin
            n = notes.pop_front();
            check("cycle", cyc, n.cyc);
            check("cmd_type", cmd_type, n.t);
            check("autoclose", autoclose, n.ac);
            check("close_all", close_all, n.ca);
            check("burst_short", burst_short, n.bs);
            if (n.is_act)
                check("row_addr", row_addr, n.row);
            if (n.is_rw)
                check("col_addr", col_addr, n.col);
            if (n.kb)
                check("bank_addr", bank_addr, n.bank);
            if (n.kg)
                check("group_addr", group_addr, n.grp);
            if (n.is_mrw) begin
                check("mr_opcode", mr_opcode, n.op);
                check("mr_select", mr_select, n.sel);
            end
        end else if (resetn === 1'b1)
            check("cmd_valid", cmd_valid, 0);
    end
endmodule : tb
